// file: hdl/trl_pkg.sv
// Constants shared by the timer readback ends.
// Operation
// - Host stops count clock before plain reads
// - Port 11 with format 00 is latch
// - Latch freezes count until read or reprogram
// - Latches leave mode intact, counters independent
// - Second latch on unread count is ignored
// - Reads follow byte format, interleaving allowed
// - Read and write byte order tracked separately
// - Host never splits two-byte reads across routines
// - Read-back command decode: count, status, selects
// - Count read-back latches each selected counter
// - Repeated count read-back on unread ignored
// - Status readable only after latch, own port
// - Status: out level, load pending, config
// - Control word sets pending only its counter
// - Count write sets pending, load clears
// - Repeated status latch on unread ignored
// - Combined read-back latches only unlatched parts
// - Status read first, then count, then live
// - Strobe decode; port 11 reads stay undriven
// - Host writes don't-care bits as zero
// - Format 01 low, 10 high, 11 both
package trl_pkg;
  localparam int         TRL_NCNT        = 3;
  localparam logic [1:0] TRL_PORT_CTRL   = 2'h3;
  localparam logic [1:0] TRL_FMT_LATCH   = 2'h0;
  localparam logic [1:0] TRL_FMT_LOW     = 2'h1;
  localparam logic [1:0] TRL_FMT_HIGH    = 2'h2;
  localparam logic [1:0] TRL_FMT_BOTH    = 2'h3;
  localparam logic [1:0] TRL_SEL_RDBK    = 2'h3;
  localparam int         TRL_CW_SEL_LSB  = 6;
  localparam int         TRL_CW_FMT_LSB  = 4;
  localparam int         TRL_RB_COUNT    = 5;
  localparam int         TRL_RB_STATUS   = 4;
  localparam int         TRL_RB_CNT0     = 1;
  localparam int         TRL_RB_RSVD     = 0;
  localparam logic [7:0] TRL_BUS_IDLE    = 8'hff;
  // Host side register map, AXI4-Lite byte addresses.
  localparam logic [3:0] TRL_REG_CMD     = 4'h0;
  localparam logic [3:0] TRL_REG_STAT    = 4'h4;
  localparam int         TRL_CMD_PORT    = 8;
  localparam int         TRL_CMD_READ    = 16;
  localparam int         TRL_STAT_RDATA  = 8;
  localparam int         TRL_STROBE_CYC  = 3;
  localparam logic [1:0] TRL_RESP_OKAY   = 2'h0;
  localparam logic [1:0] TRL_RESP_SLVERR = 2'h2;
  typedef enum logic [1:0] {
    TRL_IDLE  = 2'b00,
    TRL_SETUP = 2'b01,
    TRL_STRB  = 2'b10,
    TRL_RECOV = 2'b11
  } trl_state_t;
endpackage

// file: hdl/trl_if.sv
// Byte-wide peripheral bus joining host and timer.
`timescale 1ns/1ps
interface trl_if;
  logic       cs_n;
  logic       rd_n;
  logic       wr_n;
  logic [1:0] port_sel;
  logic [7:0] host_dq;
  logic       host_oe_n;
  logic [7:0] dev_dq;
  logic       dev_oe_n;
  logic [7:0] dq;
  // Undriven lines float high; no real pull-up strength is modelled.
  assign dq = !dev_oe_n ? dev_dq : (!host_oe_n ? host_dq : trl_pkg::TRL_BUS_IDLE);
  modport dev  (input cs_n, rd_n, wr_n, port_sel, dq, output dev_dq, dev_oe_n);
  modport host (input dq, output cs_n, rd_n, wr_n, port_sel, host_dq, host_oe_n);
endinterface

// file: hdl/trl_dev.sv
// Timer end: bus decode, hold latches, status and byte sequencing.
`timescale 1ns/1ps
module trl_dev
  import trl_pkg::*;
(
  input  wire logic             clk_sys,
  input  wire logic             rst,
  trl_if.dev                    bus,
  input  wire logic [2:0][15:0] ce_count,
  input  wire logic [2:0]       out_level,
  input  wire logic [2:0]       load_done,
  output logic      [2:0][15:0] cr_value,
  output logic      [2:0]       cr_load,
  output logic      [2:0][5:0]  cfg_value,
  output logic      [2:0]       cfg_load
);
  logic             rd_act_q;
  logic             wr_act_q;
  logic [1:0]       port_q;
  logic [7:0]       wdat_q;
  logic [7:0]       rdat_q;
  logic             rd_now;
  logic             wr_now;
  logic             rd_end;
  logic             wr_end;
  logic             cw_wr;
  logic             rb_cmd;
  logic [1:0]       cw_sel;
  logic [1:0]       cw_fmt;
  logic [2:0]       cnt_wr;
  logic [2:0]       cnt_rd;
  logic [2:0]       do_cfg;
  logic [2:0]       do_olat;
  logic [2:0]       do_slat;
  logic [2:0][15:0] ol_q;
  logic [2:0]       ol_held_q;
  logic [2:0][7:0]  st_q;
  logic [2:0]       st_held_q;
  logic [2:0]       rd_hi_q;
  logic [2:0]       wr_hi_q;
  logic [2:0]       null_q;
  logic [2:0][7:0]  rbyte;

  assign rd_now       = !bus.cs_n && !bus.rd_n && bus.wr_n;
  assign wr_now       = !bus.cs_n && !bus.wr_n && bus.rd_n;
  assign bus.dev_oe_n = !(rd_now && bus.port_sel != TRL_PORT_CTRL);
  assign bus.dev_dq   = rdat_q;
  // Accesses act on the trailing edge of the strobe, as the part does.
  assign rd_end       = rd_act_q && !rd_now;
  assign wr_end       = wr_act_q && !wr_now;
  assign cw_wr        = wr_end && port_q == TRL_PORT_CTRL;
  assign cw_sel       = wdat_q[TRL_CW_SEL_LSB +: 2];
  assign cw_fmt       = wdat_q[TRL_CW_FMT_LSB +: 2];
  // Read-back decode, reserved bit must be zero
  assign rb_cmd       = cw_wr && cw_sel == TRL_SEL_RDBK && !wdat_q[TRL_RB_RSVD];

  always_comb
  begin
    for (int i = 0; i < TRL_NCNT; i++)
    begin
      cnt_wr[i]  = wr_end && port_q == 2'(i);
      cnt_rd[i]  = rd_end && port_q == 2'(i);
      do_cfg[i]  = cw_wr && cw_sel == 2'(i) && cw_fmt != TRL_FMT_LATCH;
      do_olat[i] = cw_wr && cw_sel == 2'(i) && cw_fmt == TRL_FMT_LATCH;
      // Read-back count acts as a latch
      if (rb_cmd && wdat_q[TRL_RB_CNT0 + i] && !wdat_q[TRL_RB_COUNT])
        do_olat[i] = 1'b1;
      do_slat[i] = rb_cmd && wdat_q[TRL_RB_CNT0 + i] && !wdat_q[TRL_RB_STATUS];
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      rd_act_q <= 1'b0;
      wr_act_q <= 1'b0;
      port_q   <= 2'h0;
      wdat_q   <= 8'h00;
    end
    else
    begin
      rd_act_q <= rd_now;
      wr_act_q <= wr_now;
      if (rd_now || wr_now)
        port_q <= bus.port_sel;
      if (wr_now)
        wdat_q <= bus.dq;
    end
  end

  // Configuration: format, mode and decade bits per counter.
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      cfg_value <= '0;
      cfg_load  <= 3'h0;
    end
    else
    begin
      for (int i = 0; i < TRL_NCNT; i++)
      begin
        cfg_load[i] <= do_cfg[i];
        if (do_cfg[i])
          cfg_value[i] <= wdat_q[5:0];
      end
    end
  end

  // Count hold latches.
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      ol_q      <= '0;
      ol_held_q <= 3'h0;
    end
    else
    begin
      for (int i = 0; i < TRL_NCNT; i++)
      begin
        if (do_cfg[i])
          ol_held_q[i] <= 1'b0;
        else if (cnt_rd[i] && !st_held_q[i] &&
                 !(cfg_value[i][5:4] == TRL_FMT_BOTH && !rd_hi_q[i]))
          ol_held_q[i] <= 1'b0;
        // Only an unlatched count is captured
        else if (do_olat[i] && !ol_held_q[i])
        begin
          ol_q[i]      <= ce_count[i];
          ol_held_q[i] <= 1'b1;
        end
      end
    end
  end

  // Latched status and load-pending flags.
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      st_q      <= '0;
      st_held_q <= 3'h0;
      null_q    <= 3'h0;
    end
    else
    begin
      for (int i = 0; i < TRL_NCNT; i++)
      begin
        // Transfer into down counter clears pending
        if (load_done[i])
          null_q[i] <= 1'b0;
        // Control word sets pending for its counter only
        if (do_cfg[i])
          null_q[i] <= 1'b1;
        // Count write sets pending, second byte for pairs
        if (cnt_wr[i] && cfg_value[i][5:4] != TRL_FMT_LATCH &&
            !(cfg_value[i][5:4] == TRL_FMT_BOTH && !wr_hi_q[i]))
          null_q[i] <= 1'b1;
        if (do_cfg[i])
          st_held_q[i] <= 1'b0;
        // Status is the first byte returned
        else if (cnt_rd[i] && st_held_q[i])
          st_held_q[i] <= 1'b0;
        else if (do_slat[i] && !st_held_q[i])
        begin
          // Output level, pending flag, programmed config
          st_q[i]      <= {out_level[i], null_q[i], cfg_value[i]};
          st_held_q[i] <= 1'b1;
        end
      end
    end
  end

  // Read and write byte pointers, each counter on its own.
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      rd_hi_q  <= 3'h0;
      wr_hi_q  <= 3'h0;
      cr_value <= '0;
      cr_load  <= 3'h0;
    end
    else
    begin
      for (int i = 0; i < TRL_NCNT; i++)
      begin
        cr_load[i] <= 1'b0;
        if (do_cfg[i])
        begin
          rd_hi_q[i] <= 1'b0;
          wr_hi_q[i] <= 1'b0;
        end
        else
        begin
          // Read pointer moves only on count reads
          if (cnt_rd[i] && !st_held_q[i] && cfg_value[i][5:4] == TRL_FMT_BOTH)
            rd_hi_q[i] <= !rd_hi_q[i];
          if (cnt_wr[i])
          begin
            // Byte format selects the access pattern
            unique case (cfg_value[i][5:4])
              TRL_FMT_LOW:
              begin
                cr_value[i] <= {8'h00, wdat_q};
                cr_load[i]  <= 1'b1;
              end
              TRL_FMT_HIGH:
              begin
                cr_value[i] <= {wdat_q, 8'h00};
                cr_load[i]  <= 1'b1;
              end
              TRL_FMT_BOTH:
              begin
                // Write pointer separate from read pointer
                wr_hi_q[i] <= !wr_hi_q[i];
                if (wr_hi_q[i])
                begin
                  cr_value[i][15:8] <= wdat_q;
                  cr_load[i]        <= 1'b1;
                end
                else
                  cr_value[i] <= {8'h00, wdat_q};
              end
              TRL_FMT_LATCH:
                cr_load[i] <= 1'b0;
            endcase
          end
        end
      end
    end
  end

  // Byte offered to a read: status, latch, then live
  always_comb
  begin
    for (int i = 0; i < TRL_NCNT; i++)
    begin
      logic [15:0] v;
      v = ol_held_q[i] ? ol_q[i] : ce_count[i];
      if (st_held_q[i])
        rbyte[i] = st_q[i];
      else if (cfg_value[i][5:4] == TRL_FMT_HIGH ||
               (cfg_value[i][5:4] == TRL_FMT_BOTH && rd_hi_q[i]))
        rbyte[i] = v[15:8];
      else
        rbyte[i] = v[7:0];
    end
  end

  // Data leaves a flop loaded during the setup cycle; it is valid from the first cycle of a read strobe.
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      rdat_q <= 8'h00;
    else if (bus.port_sel != TRL_PORT_CTRL)
      rdat_q <= rbyte[bus.port_sel];
  end
endmodule

// file: hdl/trl_host.sv
// Host end: AXI4-Lite command registers driving the byte-wide timer bus.
`timescale 1ns/1ps
module trl_host
  import trl_pkg::*;
#(
  parameter int STRB_CYC = TRL_STROBE_CYC
)
(
  input  wire logic        clk_sys,
  input  wire logic        rst,
  trl_if.host              bus,
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  generate
    if (STRB_CYC < 2 || STRB_CYC > 256)
      $error("STRB_CYC must lie between 2 and 256");
  endgenerate

  trl_state_t  state_q;
  logic        aw_got_q;
  logic        w_got_q;
  logic [3:0]  aw_q;
  logic [31:0] wd_q;
  logic        ws_q;
  logic        is_rd_q;
  logic [1:0]  port_q;
  logic [7:0]  dout_q;
  logic [7:0]  rdata_q;
  logic [7:0]  cyc_q;
  logic        go;

  assign s_axi_awready = !aw_got_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_got_q && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  // A command written while busy, or with no byte lane enabled, is answered but dropped.
  assign go = aw_got_q && w_got_q && !s_axi_bvalid && aw_q == TRL_REG_CMD &&
              ws_q && state_q == TRL_IDLE;

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      aw_got_q     <= 1'b0;
      w_got_q      <= 1'b0;
      aw_q         <= 4'h0;
      wd_q         <= 32'h0;
      ws_q         <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= TRL_RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_got_q <= 1'b1;
        aw_q     <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_got_q <= 1'b1;
        wd_q    <= s_axi_wdata;
        ws_q    <= |s_axi_wstrb;
      end
      if (aw_got_q && w_got_q && !s_axi_bvalid)
      begin
        aw_got_q     <= 1'b0;
        w_got_q      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_q == TRL_REG_CMD) ? TRL_RESP_OKAY : TRL_RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= TRL_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= TRL_RESP_OKAY;
      s_axi_rdata  <= 32'h0;
      if (s_axi_araddr == TRL_REG_STAT)
        s_axi_rdata <= {16'h0, rdata_q, 7'h0, state_q != TRL_IDLE};
      else if (s_axi_araddr != TRL_REG_CMD)
        s_axi_rresp <= TRL_RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // Sequencer: setup, strobe of STRB_CYC cycles, one recovery cycle.
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      state_q <= TRL_IDLE;
      cyc_q   <= 8'h0;
      is_rd_q <= 1'b0;
      port_q  <= 2'h0;
      dout_q  <= 8'h00;
      rdata_q <= 8'h00;
    end
    else
    begin
      unique case (state_q)
        TRL_IDLE:
          if (go)
          begin
            is_rd_q <= wd_q[TRL_CMD_READ];
            port_q  <= wd_q[TRL_CMD_PORT +: 2];
            dout_q  <= wd_q[7:0];
            state_q <= TRL_SETUP;
          end
        TRL_SETUP:
        begin
          cyc_q   <= 8'h0;
          state_q <= TRL_STRB;
        end
        TRL_STRB:
        begin
          cyc_q <= cyc_q + 8'h1;
          if (cyc_q == 8'(STRB_CYC - 1))
          begin
            if (is_rd_q)
              rdata_q <= bus.dq;
            state_q <= TRL_RECOV;
          end
        end
        TRL_RECOV:
          state_q <= TRL_IDLE;
      endcase
    end
  end

  // Order of accesses and command bits are software's duty
  assign bus.cs_n      = (state_q == TRL_IDLE);
  assign bus.rd_n      = !(state_q == TRL_STRB && is_rd_q);
  assign bus.wr_n      = !(state_q == TRL_STRB && !is_rd_q);
  assign bus.port_sel  = port_q;
  assign bus.host_dq   = dout_q;
  // Host drives data only while writing
  assign bus.host_oe_n = !(state_q != TRL_IDLE && !is_rd_q);
  // Byte pairing left to the issuing software
endmodule

// file: dv/trl_assertions.sv
// Timing and decode checks on the byte-wide bus between host and timer ends.
`timescale 1ns/1ps
module trl_assertions
(
  input logic       clk_sys,
  input logic       rst,
  input logic       cs_n,
  input logic       rd_n,
  input logic       wr_n,
  input logic [1:0] port_sel,
  input logic [7:0] host_dq,
  input logic       host_oe_n,
  input logic [7:0] dev_dq,
  input logic       dev_oe_n,
  input logic [7:0] dq
);
  default clocking dcb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  property p_oe_decode;
    !dev_oe_n == (!cs_n && !rd_n && wr_n && port_sel != 2'h3);
  endproperty
  a_oe_decode: assert property (p_oe_decode) else $error("read drive decode wrong");
  property p_ctrl_rd;
    (!cs_n && !rd_n && port_sel == 2'h3) |-> dev_oe_n;
  endproperty
  a_ctrl_rd: assert property (p_ctrl_rd) else $error("command port read driven");
  property p_desel;
    cs_n |-> dev_oe_n && rd_n && wr_n;
  endproperty
  a_desel: assert property (p_desel) else $error("activity while deselected");
  // The strobe is held low for exactly three cycles, the default STRB_CYC, then released.
  property p_strobe;
    ($fell(rd_n) || $fell(wr_n)) |-> (!rd_n || !wr_n) [*3] ##1 (rd_n && wr_n);
  endproperty
  a_strobe: assert property (p_strobe) else $error("strobe length wrong");
  property p_setup;
    $fell(cs_n) |-> rd_n && wr_n ##1 (!rd_n || !wr_n);
  endproperty
  a_setup: assert property (p_setup) else $error("setup cycle missing");
  property p_recov;
    ($rose(rd_n) || $rose(wr_n)) |-> !cs_n ##1 cs_n;
  endproperty
  a_recov: assert property (p_recov) else $error("recovery cycle wrong");
  property p_wr_drive;
    !wr_n |-> !host_oe_n && dev_oe_n && dq == host_dq;
  endproperty
  a_wr_drive: assert property (p_wr_drive) else $error("write data not on bus");
  property p_port_hold;
    (!cs_n && !$past(cs_n)) |-> $stable(port_sel);
  endproperty
  a_port_hold: assert property (p_port_hold) else $error("port moved in access");
  property p_rd_data;
    (!rd_n && !$past(rd_n) && !$past(rd_n, 2)) |->
      $stable(dev_dq) && dq == (dev_oe_n ? 8'hff : dev_dq);
  endproperty
  a_rd_data: assert property (p_rd_data) else $error("read data unsteady");

  c_rd: cover property ($fell(rd_n));
  c_wr_ctrl: cover property ($fell(wr_n) && port_sel == 2'h3);
  c_rd_two: cover property (!dev_oe_n && port_sel == 2'h2);
endmodule

// file: dv/tb.sv
// Self-checking bench joining host and timer ends over the byte bus.
`timescale 1ns/1ps
module tb import trl_pkg::*;;
  typedef struct packed
  {
    logic       rd;
    logic [1:0] port;
    logic [7:0] data;
    logic [7:0] exp;
  } trl_row_t;
  logic             clk_sys, rst;
  logic [2:0][15:0] ce_count, cr_value;
  logic [2:0]       out_level, load_done, cr_load, cfg_load;
  logic [2:0][5:0]  cfg_value;
  logic [3:0]       s_axi_awaddr, s_axi_wstrb, s_axi_araddr;
  logic [31:0]      s_axi_wdata, s_axi_rdata, v;
  logic [1:0]       s_axi_bresp, s_axi_rresp, r;
  logic             s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic             s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic             s_axi_rvalid, s_axi_rready;
  int               n_fail, comparisons;
  int               cyc = 0;
  int               n_cr_load = 0, n_cfg_load = 0;
  localparam trl_row_t ROWS [8] = '{'{1'h0, 2'h3, 8'h34, 8'h00}, '{1'h1, 2'h0, 8'h00, 8'h34},
    '{1'h1, 2'h0, 8'h00, 8'h12}, '{1'h0, 2'h3, 8'h50, 8'h00}, '{1'h1, 2'h1, 8'h00, 8'h78},
    '{1'h1, 2'h1, 8'h00, 8'h78}, '{1'h0, 2'h3, 8'ha0, 8'h00}, '{1'h1, 2'h2, 8'h00, 8'h9a}};

  trl_if i_trl_if ();
  trl_dev i_trl_dev (.clk_sys, .rst, .bus(i_trl_if.dev), .ce_count, .out_level, .load_done,
    .cr_value, .cr_load, .cfg_value, .cfg_load);
  trl_host i_trl_host (.clk_sys, .rst, .bus(i_trl_if.host), .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  trl_assertions i_trl_assertions (.clk_sys, .rst, .cs_n(i_trl_if.cs_n),
    .rd_n(i_trl_if.rd_n), .wr_n(i_trl_if.wr_n), .port_sel(i_trl_if.port_sel),
    .host_dq(i_trl_if.host_dq), .host_oe_n(i_trl_if.host_oe_n), .dev_dq(i_trl_if.dev_dq),
    .dev_oe_n(i_trl_if.dev_oe_n), .dq(i_trl_if.dq));

  initial
  begin
    clk_sys = 1'h0;
    forever #5 clk_sys = ~clk_sys;
  end

  task tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // The ceiling is dozens of times the expected run, so only a hang reaches it.
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
      n_fail++;
      tally_and_finish;
    end
  end

  // Load pulses last one cycle, so they are counted here and checked at the end.
  always @(posedge clk_sys)
    if (!rst)
    begin
      n_cr_load <= n_cr_load + $countones(cr_load);
      n_cfg_load <= n_cfg_load + $countones(cfg_load);
    end

  task chk(input logic [15:0] s, input logic [15:0] e);
    comparisons++;
    if (s !== e)
    begin
      n_fail++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, s, e);
    end
  endtask

  task axw(input logic [3:0] a, input logic [31:0] d, output logic [1:0] q);
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    do
    begin
      @(posedge clk_sys);
      if (s_axi_awready)
        s_axi_awvalid <= 1'h0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'h0;
    end
    while (!s_axi_bvalid);
    q = s_axi_bresp;
    s_axi_bready <= 1'h0;
  endtask

  task axr(input logic [3:0] a, output logic [31:0] d, output logic [1:0] q);
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    do
    begin
      @(posedge clk_sys);
      if (s_axi_arready)
        s_axi_arvalid <= 1'h0;
    end
    while (!s_axi_rvalid);
    d = s_axi_rdata;
    q = s_axi_rresp;
    s_axi_rready <= 1'h0;
  endtask

  // One timer bus access; waits for the sequencer to go idle before returning.
  task op(input logic rd, input logic [1:0] p, input logic [7:0] d, output logic [7:0] q);
    axw(TRL_REG_CMD, {15'h0, rd, 6'h0, p, d}, r);
    v = 32'h1;
    while (v[0])
      axr(TRL_REG_STAT, v, r);
    q = v[15:8];
  endtask

  task wr(input logic [1:0] p, input logic [7:0] d);
    logic [7:0] q;
    op(1'h0, p, d, q);
  endtask

  task rdx(input logic [1:0] p, input logic [7:0] e);
    logic [7:0] q;
    op(1'h1, p, 8'h0, q);
    chk(16'(q), 16'(e));
  endtask

  initial
  begin
    rst = 1'h1;
    ce_count = {16'h9abc, 16'h5678, 16'h1234};
    out_level = 3'h5;
    load_done = 3'h0;
    s_axi_awaddr = 4'h0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    s_axi_awvalid = 1'h0;
    s_axi_wvalid = 1'h0;
    s_axi_bready = 1'h0;
    s_axi_araddr = 4'h0;
    s_axi_arvalid = 1'h0;
    s_axi_rready = 1'h0;
    repeat (16) @(posedge clk_sys);
    rst <= 1'h0;
    // Counts change between accesses only; spare command bits are zero.
    foreach (ROWS[i])
      if (ROWS[i].rd)
        rdx(ROWS[i].port, ROWS[i].exp);
      else
        wr(ROWS[i].port, ROWS[i].data);
    $display("rows done");
    wr(2'h3, 8'h00);
    ce_count[0] <= 16'h4321;
    wr(2'h3, 8'h00);
    rdx(2'h0, 8'h34);
    rdx(2'h0, 8'h12);
    rdx(2'h0, 8'h21);
    chk(16'(cfg_value[0]), 16'h34);
    rdx(2'h0, 8'h43);
    rdx(2'h0, 8'h21);
    wr(2'h0, 8'h11);
    rdx(2'h0, 8'h43);
    wr(2'h0, 8'h22);
    chk(cr_value[0], 16'h2211);
    $display("latch done");
    load_done <= 3'h7;
    @(posedge clk_sys);
    load_done <= 3'h0;
    wr(2'h3, 8'h50);
    wr(2'h3, 8'hee);
    out_level <= 3'h2;
    wr(2'h3, 8'he4);
    rdx(2'h0, 8'hb4);
    rdx(2'h1, 8'h50);
    rdx(2'h2, 8'ha0);
    rdx(2'h1, 8'h78);
    $display("status done");
    wr(2'h2, 8'h55);
    chk(cr_value[2], 16'h5500);
    wr(2'h3, 8'hd2);
    ce_count[0] <= 16'h0bad;
    wr(2'h3, 8'hca);
    ce_count[2] <= 16'h1111;
    wr(2'h3, 8'hc2);
    rdx(2'h0, 8'h34);
    rdx(2'h0, 8'h21);
    rdx(2'h0, 8'h43);
    rdx(2'h0, 8'had);
    rdx(2'h2, 8'h60);
    rdx(2'h2, 8'h9a);
    $display("read-back done");
    wr(2'h3, 8'h00);
    ce_count[0] <= 16'h7e57;
    wr(2'h3, 8'h34);
    rdx(2'h0, 8'h57);
    rdx(2'h0, 8'h7e);
    wr(2'h3, 8'hc3);
    ce_count[0] <= 16'h2468;
    rdx(2'h0, 8'h68);
    rdx(2'h3, TRL_BUS_IDLE);
    axw(4'h8, 32'h0, r);
    chk(16'(r), 16'(TRL_RESP_SLVERR));
    axr(4'h8, v, r);
    chk(16'(r), 16'(TRL_RESP_SLVERR));
    chk(16'(n_cr_load), 16'h2);
    chk(16'(n_cfg_load), 16'h5);
    $display("awkward done");
    rst <= 1'h1;
    repeat (2) @(posedge clk_sys);
    chk(16'(cfg_value[0]), 16'h0);
    chk(16'(i_trl_if.cs_n), 16'h1);
    rst <= 1'h0;
    rdx(2'h0, 8'h68);
    $display("reset done");
    tally_and_finish;
  end
endmodule
